// [hdl/fwb_cmd_ctrl.sv]
`timescale 1ns/10ps
module fwb_cmd_ctrl #(
  parameter int NV_WRITE_CYCLES = fwb_pkg::NV_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Serial link pins
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic        si_in,
  // Read address engine
  input  wire logic        read_start_in,
  input  wire logic [31:0] read_addr_in,
  input  wire logic        read_step_in,
  input  wire logic        quad_read_in,
  output logic      [31:0] read_addr_out,
  // Array fault indications
  input  wire logic        erase_fail_in,
  input  wire logic        program_fail_in,
  // Software reset pulse
  input  wire logic        soft_reset_in,
  // Status and configuration
  output logic      [7:0]  volatile_status_one_out,
  output logic             write_in_progress_flag_out,
  output logic             write_enable_latch_out,
  output logic             program_error_out,
  output logic             erase_error_out,
  output logic      [7:0]  volatile_config_two_out,
  output logic      [7:0]  volatile_config_four_out,
  output logic      [7:0]  nonvolatile_config_four_out
);
  import fwb_pkg::*;

  localparam logic [3:0] VOL_LAST = 4'(VOL_WRITE_CYCLES - 1);

  fwb_nv_if nv_bus ();
  fwb_rd_if rd_bus ();

  // Pin synchronisers; first stages feed only second stages
  logic        sck_s1, sck_s2, sck_s3;
  logic        cs_s1, cs_s2, cs_s3;
  logic        si_s1, si_s2;

  // Frame and register state
  logic [47:0] shift;
  logic [6:0]  bit_cnt;
  logic [7:0]  opcode;
  fwb_state_t  state;
  logic [3:0]  vol_cnt;
  logic [7:0]  pend_nv;
  logic        boot_load;
  logic        write_in_progress_flag;
  logic        write_enable_latch;
  logic        p_err;
  logic        e_err;
  logic [7:0]  volatile_config_two;
  logic [7:0]  volatile_config_four;
  logic [7:0]  nonvolatile_config_four;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3}    <= 3'h7;
      {si_s1, si_s2}           <= 2'h0;
    end else begin
      {sck_s1, sck_s2, sck_s3} <= {sck_in, sck_s1, sck_s2};
      {cs_s1, cs_s2, cs_s3}    <= {cs_n_in, cs_s1, cs_s2};
      {si_s1, si_s2}           <= {si_in, si_s1};
    end
  end

  wire sck_rise = sck_s2 && !sck_s3 && !cs_s2;
  wire cs_fall  = !cs_s2 && cs_s3;
  wire cs_rise  = cs_s2 && !cs_s3;

  // Frame capture; bit count saturates so overlong frames are rejected
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift   <= 48'h0;
      bit_cnt <= 7'h00;
      opcode  <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt <= 7'h00;
    end else if (sck_rise) begin
      shift <= {shift[46:0], si_s2};
      if (bit_cnt != 7'h7F)
        bit_cnt <= bit_cnt + 7'h01;
      if (bit_cnt == 7'h07)
        opcode <= {shift[6:0], si_s2};
    end
  end

  wire        addr4    = volatile_config_two[CR2_ADDR_LEN_BIT];
  wire [31:0] wr_addr  = addr4 ? shift[39:8] : {8'h00, shift[31:8]};
  wire [7:0]  wr_data  = shift[7:0];
  wire [6:0]  wr_len   = addr4 ? LEN_WRITE4 : LEN_WRITE3;
  wire        is_idle  = (state == ST_IDLE);

  wire go_write_enable_cmd  = cs_rise && is_idle && opcode == OP_WRITE_ENABLE && bit_cnt == LEN_CMD_ONLY;
  wire go_status_clear_cmd  = cs_rise && opcode == OP_STATUS_CLEAR && bit_cnt == LEN_CMD_ONLY;
  wire go_any_register_write_cmd  = cs_rise && is_idle && write_enable_latch && opcode == OP_ANY_REG_WRITE && bit_cnt == wr_len;
  wire go_sbl   = cs_rise && is_idle && opcode == OP_BURST_LEN_SET && bit_cnt == LEN_BURST;

  // Lock register and unknown addresses fall through and change no register; only the write enable latch clears
  wire hit_volatile_config_two  = wr_addr == ADDR_VOLATILE_CONFIG_TWO;
  wire hit_volatile_config_four  = wr_addr == ADDR_VOLATILE_CONFIG_FOUR;
  wire hit_nonvolatile_config_four = wr_addr == ADDR_NONVOLATILE_CONFIG_FOUR;

  wire [7:0] new_volatile_config_two = (volatile_config_two & ~VOLATILE_CONFIG_TWO_WRITE_MASK) | (wr_data & VOLATILE_CONFIG_TWO_WRITE_MASK);
  wire [7:0] new_volatile_config_four = (volatile_config_four & ~CR4_BURST_MASK) | (wr_data & CR4_BURST_MASK);
  // OTP bits move away from default only
  wire [7:0] otp_flip = (nonvolatile_config_four ^ NONVOLATILE_CONFIG_FOUR_OTP_DEFAULT) | (wr_data ^ NONVOLATILE_CONFIG_FOUR_OTP_DEFAULT);
  wire [7:0] otp_new  = (otp_flip ^ NONVOLATILE_CONFIG_FOUR_OTP_DEFAULT) & NONVOLATILE_CONFIG_FOUR_OTP_MASK;
  wire [7:0] new_nonvolatile_config_four = (nonvolatile_config_four & ~(NONVOLATILE_CONFIG_FOUR_NV_MASK | NONVOLATILE_CONFIG_FOUR_OTP_MASK))
                       | (wr_data & NONVOLATILE_CONFIG_FOUR_NV_MASK) | otp_new;

  wire nv_change  = hit_nonvolatile_config_four && (new_nonvolatile_config_four != nonvolatile_config_four);
  wire vol_change = (hit_volatile_config_two && new_volatile_config_two != volatile_config_two) || (hit_volatile_config_four && new_volatile_config_four != volatile_config_four);
  wire nv_failed  = nv_bus.erase_err || nv_bus.prog_err;

  assign nv_bus.start      = go_any_register_write_cmd && nv_change;
  assign nv_bus.erase_fail = erase_fail_in;
  assign nv_bus.prog_fail  = program_fail_in;

  // Update sequence
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state   <= ST_IDLE;
      vol_cnt <= 4'h0;
      pend_nv <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (go_any_register_write_cmd && nv_change) begin
            state   <= ST_NV;
            pend_nv <= new_nonvolatile_config_four;
          end else if (go_any_register_write_cmd && vol_change) begin
            state   <= ST_VOL;
            vol_cnt <= VOL_LAST;
          end
        end
        ST_VOL: begin
          if (vol_cnt == 4'h0)
            state <= ST_IDLE;
          else
            vol_cnt <= vol_cnt - 4'h1;
        end
        ST_NV: begin
          if (nv_bus.done)
            state <= nv_failed ? ST_FAIL : ST_IDLE;
        end
        ST_FAIL: begin
          if (go_status_clear_cmd)
            state <= ST_IDLE;
        end
      endcase
    end
  end

  wire vol_done = (state == ST_VOL) && (vol_cnt == 4'h0);
  wire nv_ok    = (state == ST_NV) && nv_bus.done && !nv_failed;
  wire nv_bad   = (state == ST_NV) && nv_bus.done && nv_failed;
  wire quick    = go_any_register_write_cmd && !nv_change && !vol_change;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      write_in_progress_flag <= 1'b0;
    else if (go_any_register_write_cmd && (nv_change || vol_change))
      write_in_progress_flag <= 1'b1;
    else if (vol_done || nv_ok || (state == ST_FAIL && go_status_clear_cmd))
      write_in_progress_flag <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      write_enable_latch <= 1'b0;
    else if (go_write_enable_cmd)
      write_enable_latch <= 1'b1;
    else if (quick || vol_done || nv_ok || nv_bad || go_status_clear_cmd)
      write_enable_latch <= 1'b0;
  end

  // Error flags; they stay until cleared
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      p_err <= 1'b0;
      e_err <= 1'b0;
    end else if (nv_bad) begin
      p_err <= nv_bus.prog_err;
      e_err <= nv_bus.erase_err;
    end else if (go_status_clear_cmd) begin
      p_err <= 1'b0;
      e_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      boot_load <= 1'b1;
    else
      boot_load <= soft_reset_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      volatile_config_two <= VOLATILE_CONFIG_TWO_RESET;
    else if (go_any_register_write_cmd && hit_volatile_config_two)
      volatile_config_two <= new_volatile_config_two;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      volatile_config_four <= VOLATILE_CONFIG_FOUR_RESET;
    else if (boot_load)
      volatile_config_four <= (volatile_config_four & ~CR4_BURST_MASK) | (nonvolatile_config_four & CR4_BURST_MASK);
    else if (go_sbl)
      volatile_config_four <= (volatile_config_four & ~CR4_BURST_MASK) | (wr_data & CR4_BURST_MASK);
    else if (go_any_register_write_cmd && hit_volatile_config_four)
      volatile_config_four <= new_volatile_config_four;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      nonvolatile_config_four <= NONVOLATILE_CONFIG_FOUR_RESET;
    else if (nv_ok)
      nonvolatile_config_four <= pend_nv;
  end

  fwb_nv_seq #(
    .NV_CYCLES (NV_WRITE_CYCLES)
  ) u_nv_seq (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .nv      (nv_bus.seq)
  );

  // Quad reads only; enabled by low bit 4
  assign rd_bus.wrap_en    = quad_read_in && !volatile_config_four[CR4_WRAP_DIS_BIT];
  assign rd_bus.wrap_size  = volatile_config_four[CR4_WRAP_LSB +: 2];
  assign rd_bus.load       = read_start_in;
  assign rd_bus.start_addr = read_addr_in;
  assign rd_bus.step       = read_step_in;

  fwb_wrap_gen u_wrap_gen (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .rd      (rd_bus.gen)
  );

  assign read_addr_out               = rd_bus.addr;
  assign write_in_progress_flag_out  = write_in_progress_flag;
  assign write_enable_latch_out      = write_enable_latch;
  assign program_error_out           = p_err;
  assign erase_error_out             = e_err;
  assign volatile_status_one_out     = {1'b0, p_err, e_err, 3'h0, write_enable_latch, write_in_progress_flag};
  assign volatile_config_two_out     = volatile_config_two;
  assign volatile_config_four_out    = volatile_config_four;
  assign nonvolatile_config_four_out = nonvolatile_config_four;
endmodule : fwb_cmd_ctrl

// [hdl/fwb_nv_seq.sv]
`timescale 1ns/10ps
module fwb_nv_seq #(
  parameter int NV_CYCLES = fwb_pkg::NV_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Control side
  fwb_nv_if.seq    nv
);
  import fwb_pkg::*;

  localparam int CW = $clog2(NV_CYCLES + 1);
  localparam logic [CW-1:0] ERASE_LAST = CW'(NV_CYCLES / 2);
  localparam logic [CW-1:0] TOTAL_LAST = CW'(NV_CYCLES - 1);

  logic [CW-1:0] cnt;
  logic          erasing;
  wire           end_erase = nv.busy && erasing && (cnt == ERASE_LAST);
  wire           end_prog  = nv.busy && !erasing && (cnt == TOTAL_LAST);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nv.busy <= 1'b0;
      erasing <= 1'b0;
      cnt     <= '0;
    end else if (nv.start && !nv.busy) begin
      nv.busy <= 1'b1;
      erasing <= 1'b1;
      cnt     <= '0;
    end else if (end_erase) begin
      erasing <= 1'b0;
      nv.busy <= !nv.erase_fail;
      cnt     <= cnt + 1'b1;
    end else if (end_prog) begin
      nv.busy <= 1'b0;
    end else if (nv.busy) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nv.done      <= 1'b0;
      nv.erase_err <= 1'b0;
      nv.prog_err  <= 1'b0;
    end else begin
      nv.done <= (end_erase && nv.erase_fail) || end_prog;
      if (nv.start && !nv.busy) begin
        nv.erase_err <= 1'b0;
        nv.prog_err  <= 1'b0;
      end else begin
        if (end_erase && nv.erase_fail)
          nv.erase_err <= 1'b1;
        if (end_prog && nv.prog_fail)
          nv.prog_err <= 1'b1;
      end
    end
  end
endmodule : fwb_nv_seq

// [hdl/fwb_wrap_gen.sv]
`timescale 1ns/10ps
module fwb_wrap_gen (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Control side
  fwb_rd_if.gen    rd
);
  import fwb_pkg::*;

  function automatic logic [31:0] group_mask(input logic en, input logic [1:0] sel);
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    if (en)
      m = {26'h0, 6'h07 << sel} | 32'h0000_0007 | {26'h0, 6'h3F >> (2'h3 - sel)};
    return m;
  endfunction : group_mask

  wire [31:0] mask  = group_mask(rd.wrap_en, rd.wrap_size);
  wire [31:0] incr  = rd.addr + 32'h0000_0001;
  wire [31:0] next_addr = (rd.addr & ~mask) | (incr & mask);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      rd.addr <= 32'h0000_0000;
    else if (rd.load)
      rd.addr <= rd.start_addr;
    else if (rd.step)
      rd.addr <= next_addr;
  end
endmodule : fwb_wrap_gen

// [include/fwb_if.sv]
`timescale 1ns/10ps
interface fwb_nv_if;
  logic start;
  logic erase_fail;
  logic prog_fail;
  logic busy;
  logic done;
  logic erase_err;
  logic prog_err;
  modport ctl (output start, erase_fail, prog_fail, input busy, done, erase_err, prog_err);
  modport seq (input start, erase_fail, prog_fail, output busy, done, erase_err, prog_err);
endinterface : fwb_nv_if

interface fwb_rd_if;
  logic        load;
  logic [31:0] start_addr;
  logic        step;
  logic        wrap_en;
  logic [1:0]  wrap_size;
  logic [31:0] addr;
  modport ctl (output load, start_addr, step, wrap_en, wrap_size, input addr);
  modport gen (input load, start_addr, step, wrap_en, wrap_size, output addr);
endinterface : fwb_rd_if

// [include/fwb_pkg.sv]
package fwb_pkg;
  // Command codes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_STATUS_CLEAR  = 8'h30;
  localparam logic [7:0] OP_ANY_REG_WRITE = 8'h71;
  localparam logic [7:0] OP_BURST_LEN_SET = 8'hC0;

  // Register byte addresses
  localparam logic [31:0] ADDR_NONVOLATILE_CONFIG_FOUR = 32'h0000_0005;
  localparam logic [31:0] ADDR_VOLATILE_STATUS_ONE  = 32'h0080_0000;
  localparam logic [31:0] ADDR_VOLATILE_CONFIG_TWO  = 32'h0080_0003;
  localparam logic [31:0] ADDR_VOLATILE_CONFIG_FOUR  = 32'h0080_0005;
  localparam logic [31:0] ADDR_PROTECTION_LOCK_REGISTER  = 32'h0080_0040;

  // Field positions
  localparam int SR1_WIP_BIT      = 0;
  localparam int SR1_WEL_BIT      = 1;
  localparam int SR1_E_ERR_BIT    = 5;
  localparam int SR1_P_ERR_BIT    = 6;
  localparam int CR2_ADDR_LEN_BIT = 7;
  localparam int CR4_WRAP_DIS_BIT = 4;
  localparam int CR4_WRAP_LSB     = 0;

  // Writable bit masks per register
  localparam logic [7:0] VOLATILE_CONFIG_TWO_WRITE_MASK   = 8'h80;
  localparam logic [7:0] CR4_BURST_MASK    = 8'h13;
  localparam logic [7:0] NONVOLATILE_CONFIG_FOUR_NV_MASK     = 8'h13;
  localparam logic [7:0] NONVOLATILE_CONFIG_FOUR_OTP_MASK    = 8'h80;
  localparam logic [7:0] NONVOLATILE_CONFIG_FOUR_OTP_DEFAULT = 8'h00;

  // Reset values
  localparam logic [7:0] VOLATILE_CONFIG_TWO_RESET  = 8'h08;
  localparam logic [7:0] VOLATILE_CONFIG_FOUR_RESET  = 8'h10;
  localparam logic [7:0] NONVOLATILE_CONFIG_FOUR_RESET = 8'h10;

  // Frame lengths in bits
  localparam logic [6:0] LEN_CMD_ONLY = 7'h08;
  localparam logic [6:0] LEN_BURST    = 7'h10;
  localparam logic [6:0] LEN_WRITE3   = 7'h28;
  localparam logic [6:0] LEN_WRITE4   = 7'h30;

  // Timing
  localparam int CLK_PERIOD_NS    = 25;
  localparam int T_NV_WRITE_US    = 1000;
  localparam int NV_WRITE_CYCLES  = (T_NV_WRITE_US * 1000) / CLK_PERIOD_NS;
  localparam int T_VOL_WRITE_NS   = 50;
  localparam int VOL_CYCLES_RAW   = T_VOL_WRITE_NS / CLK_PERIOD_NS;
  localparam int VOL_WRITE_CYCLES = (VOL_CYCLES_RAW < 1) ? 1 : VOL_CYCLES_RAW;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_VOL  = 4'b0010,
    ST_NV   = 4'b0100,
    ST_FAIL = 4'b1000
  } fwb_state_t;
endpackage : fwb_pkg

// [verif/fwb_cmd_ctrl_monitor.sv]
`timescale 1ns/10ps
module fwb_cmd_ctrl_monitor #(
  parameter int NV_WRITE_CYCLES = 20
) (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rstn_in,
  // Read address engine
  input wire logic        read_start_in,
  input wire logic [31:0] read_addr_in,
  input wire logic        read_step_in,
  input wire logic        quad_read_in,
  input wire logic [31:0] read_addr_out,
  // Status and configuration
  input wire logic [7:0]  volatile_status_one_out,
  input wire logic        write_in_progress_flag_out,
  input wire logic        write_enable_latch_out,
  input wire logic        program_error_out,
  input wire logic        erase_error_out,
  input wire logic [7:0]  volatile_config_two_out,
  input wire logic [7:0]  volatile_config_four_out,
  input wire logic [7:0]  nonvolatile_config_four_out
);
  localparam int NV_BOUND = NV_WRITE_CYCLES + 4;
  wire logic        write_in_progress_flag       = write_in_progress_flag_out;
  wire logic        write_enable_latch       = write_enable_latch_out;
  wire logic        any_err   = erase_error_out | program_error_out;
  wire logic [7:0]  cr4       = volatile_config_four_out;
  wire logic        wrap_on   = quad_read_in & ~cr4[4];
  wire logic [31:0] wrap_mask = (32'h8 << cr4[1:0]) - 32'h1;
  wire logic [31:0] wrap_addr = (read_addr_out & ~wrap_mask)
                              | ((read_addr_out + 32'h1) & wrap_mask);
  wire logic [31:0] next_read_addr = wrap_on ? wrap_addr : read_addr_out + 32'h1;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_STATUS_MAP: assert property (
    volatile_status_one_out == {1'b0, program_error_out, erase_error_out, 3'b000, write_enable_latch, write_in_progress_flag})
    else $error("status byte does not match flags");
  AST_ERR_HOLDS_WIP: assert property (
    any_err |-> write_in_progress_flag) else $error("error flag without progress flag");
  AST_CR4_OTHER: assert property (
    $changed(cr4) |-> ((cr4 ^ $past(cr4)) & 8'hEC) == 8'h00)
    else $error("config four changed outside burst bits");
  AST_CR2_RO: assert property (
    (volatile_config_two_out & 8'h7F) == 8'h08) else $error("config two read-only bits moved");
  AST_LOAD: assert property (
    read_start_in |=> read_addr_out == $past(read_addr_in)) else $error("read start not loaded");
  AST_STEP: assert property (
    read_step_in && !read_start_in |=> read_addr_out == $past(next_read_addr))
    else $error("read step address wrong");
  AST_OTP: assert property (
    $past(nonvolatile_config_four_out[7]) |-> nonvolatile_config_four_out[7])
    else $error("programmed bit returned to default");
  AST_WEL_DONE: assert property (
    $fell(write_in_progress_flag) |-> !write_enable_latch) else $error("write enable kept after completion");
  AST_NV_BOUND: assert property (
    $rose(write_in_progress_flag) |-> ##[1:NV_BOUND] (!write_in_progress_flag || any_err)) else $error("update overran its time");
  AST_CR2_GATE: assert property (
    $changed(volatile_config_two_out) |-> $past(write_enable_latch)) else $error("write without enable");
endmodule : fwb_cmd_ctrl_monitor

bind fwb_cmd_ctrl fwb_cmd_ctrl_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_mon (
  .clk_in, .rstn_in, .read_start_in, .read_addr_in, .read_step_in, .quad_read_in,
  .read_addr_out, .volatile_status_one_out, .write_in_progress_flag_out,
  .write_enable_latch_out, .program_error_out, .erase_error_out,
  .volatile_config_two_out, .volatile_config_four_out, .nonvolatile_config_four_out);

// [verif/fwb_host_model.sv]
`timescale 1ns/10ps
module fwb_host_model (
  // Link pins
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out
);
  // Half period of the link clock, four system clocks per level
  int half_ns = 100;

  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b0;
  end

  task automatic send(input logic [47:0] v, input int n);
    cs_n_out = 1'b0;
    #(half_ns);
    for (int i = n - 1; i >= 0; i--) begin
      si_out = v[i];
      #(half_ns) sck_out = 1'b1;
      #(half_ns) sck_out = 1'b0;
    end
    #(half_ns) cs_n_out = 1'b1;
    // Released data line must not keep its last level
    si_out = ~si_out;
    #(4 * half_ns);
  endtask : send
endmodule : fwb_host_model

// [verif/tb_flash_register_write_and_burst_wrap.sv]
`timescale 1ns/10ps
module tb_flash_register_write_and_burst_wrap;
  import fwb_pkg::*;
  logic        clk_in, rstn_in, sck, cs_n, si, write_in_progress_flag, write_enable_latch, perr, eerr;
  logic        read_start, read_step, quad_read, erase_fail, program_fail, soft_reset;
  logic [31:0] read_addr, raddr;
  logic [7:0]  sr1, cr2, cr4, nonvolatile_config_four;
  int          failures = 0;
  int          check_count = 0;

  fwb_host_model i_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si));
  fwb_cmd_ctrl #(.NV_WRITE_CYCLES(20)) i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .read_start_in(read_start), .read_addr_in(read_addr), .read_step_in(read_step),
    .quad_read_in(quad_read), .read_addr_out(raddr), .erase_fail_in(erase_fail),
    .program_fail_in(program_fail), .soft_reset_in(soft_reset),
    .volatile_status_one_out(sr1), .write_in_progress_flag_out(write_in_progress_flag),
    .write_enable_latch_out(write_enable_latch), .program_error_out(perr), .erase_error_out(eerr),
    .volatile_config_two_out(cr2), .volatile_config_four_out(cr4),
    .nonvolatile_config_four_out(nonvolatile_config_four));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic test_done;
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t address got %h exp %h", $time, got, exp);
    end
  endtask : chk32

  // Bounded wait for the update to finish
  task automatic frame(input logic [47:0] v, input int n);
    int k;
    i_host.send(v, n);
    k = 0;
    while (write_in_progress_flag !== 1'b0 && k < 200) begin
      @(posedge clk_in);
      k++;
    end
    if (k == 200) begin
      failures++;
      $display("[FAIL] %0t update did not finish", $time);
      test_done();
    end
    #1;
  endtask : frame

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_clk

  task automatic t_regs;
    #1;
    chk8(cr4, 8'h10);
    frame({8'h0, OP_ANY_REG_WRITE, ADDR_VOLATILE_CONFIG_TWO[23:0], 8'hFF}, 40);
    chk8(cr2, 8'h08);
    frame({40'h0, OP_WRITE_ENABLE}, 8);
    chk8(sr1, 8'h02);
    i_host.send({8'h0, OP_ANY_REG_WRITE, ADDR_VOLATILE_CONFIG_TWO[23:0], 8'hFF}, 40);
    wait_clk(2);
    chk8(sr1, 8'h00);
    chk8(cr2, 8'h88);
    frame({40'h0, OP_WRITE_ENABLE}, 8);
    frame({OP_ANY_REG_WRITE, ADDR_PROTECTION_LOCK_REGISTER, 8'hFF}, 48);
    chk8(sr1, 8'h00);
  endtask : t_regs

  task automatic t_read(input logic [7:0] cfg, input logic quad, input logic [31:0] a,
                        input int n);
    logic [31:0] e;
    logic [31:0] m;
    e = a;
    m = (cfg[4] || !quad) ? 32'hFFFF_FFFF : (32'h8 << cfg[1:0]) - 32'h1;
    frame({32'h0, OP_BURST_LEN_SET, cfg}, 16);
    chk8(cr4, cfg & 8'h13);
    @(posedge clk_in);
    quad_read  <= quad;
    read_start <= 1'b1;
    read_addr  <= a;
    @(posedge clk_in);
    read_start <= 1'b0;
    read_step  <= 1'b1;
    #1;
    chk32(raddr, a);
    for (int i = 0; i < n; i++) begin
      e = (e & ~m) | ((e + 32'h1) & m);
      wait_clk(1);
      chk32(raddr, e);
    end
    @(posedge clk_in);
    read_step <= 1'b0;
  endtask : t_read

  task automatic t_nv;
    int k;
    frame({40'h0, OP_WRITE_ENABLE}, 8);
    i_host.send({OP_ANY_REG_WRITE, ADDR_NONVOLATILE_CONFIG_FOUR, 8'h82}, 48);
    k = 0;
    while (write_in_progress_flag !== 1'b1 && k < 20) begin
      @(posedge clk_in);
      k++;
    end
    if (k == 20) begin
      failures++;
      $display("[FAIL] %0t update did not start", $time);
      test_done();
    end
    #1;
    chk8(sr1, 8'h03);
    frame({40'h0, 8'h0}, 0);
    chk8(nonvolatile_config_four, 8'h82);
    @(posedge clk_in);
    soft_reset <= 1'b1;
    @(posedge clk_in);
    soft_reset <= 1'b0;
    wait_clk(3);
    chk8(cr4, 8'h02);
    frame({40'h0, OP_WRITE_ENABLE}, 8);
    frame({OP_ANY_REG_WRITE, ADDR_NONVOLATILE_CONFIG_FOUR, 8'h13}, 48);
    chk8(nonvolatile_config_four, 8'h93);
    chk8(sr1, 8'h00);
  endtask : t_nv

  task automatic t_fail(input logic prog);
    @(posedge clk_in);
    erase_fail   <= ~prog;
    program_fail <= prog;
    frame({40'h0, OP_WRITE_ENABLE}, 8);
    i_host.send({OP_ANY_REG_WRITE, ADDR_NONVOLATILE_CONFIG_FOUR, 8'h80}, 48);
    wait_clk(40);
    chk8(sr1, prog ? 8'h41 : 8'h21);
    i_host.send({40'h0, OP_WRITE_ENABLE}, 8);
    wait_clk(2);
    chk8(sr1, prog ? 8'h41 : 8'h21);
    @(posedge clk_in);
    erase_fail   <= 1'b0;
    program_fail <= 1'b0;
    frame({40'h0, OP_STATUS_CLEAR}, 8);
    chk8(sr1, 8'h00);
  endtask : t_fail

  initial begin
    rstn_in      = 1'b0;
    read_start   = 1'b0;
    read_step    = 1'b0;
    quad_read    = 1'b0;
    erase_fail   = 1'b0;
    program_fail = 1'b0;
    soft_reset   = 1'b0;
    read_addr    = 32'h0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_regs();
    t_read(8'hEC, 1'b1, 32'h1234_5607, 9);
    t_read(8'h01, 1'b1, 32'h0000_000C, 17);
    t_read(8'h02, 1'b1, 32'h0000_001E, 33);
    t_read(8'h03, 1'b1, 32'h0000_002E, 65);
    t_read(8'h13, 1'b1, 32'h0000_003F, 3);
    t_read(8'h01, 1'b0, 32'h0000_00FE, 4);
    t_nv();
    t_fail(1'b0);
    t_fail(1'b1);
    test_done();
  end
endmodule : tb_flash_register_write_and_burst_wrap
